// ---- vfr_pkg.sv ----
package vfr_pkg;
   // ****************************************************************
   // Command codes
   // ****************************************************************
   localparam logic [7:0] VFR_CMD_OV_ACTION = 8'h41;
   localparam logic [7:0] VFR_CMD_UV_ACTION = 8'h45;
   // ****************************************************************
   // Response byte layout
   // ****************************************************************
   localparam int VFR_IGNORE_SELECT_BIT = 7;
   localparam int VFR_FIXED_ZERO_BIT = 6;
   localparam int VFR_RETRY_MODE_MSB = 5;
   localparam int VFR_RETRY_MODE_LSB = 3;
   localparam int VFR_RETRY_DELAY_MSB = 2;
   localparam int VFR_RETRY_DELAY_LSB = 0;
   localparam logic [2:0] VFR_RETRY_NONE = 3'h0;
   localparam logic [2:0] VFR_RETRY_ALWAYS = 3'h7;
   localparam logic [7:0] VFR_UV_ACTION_RESET = 8'hBF;
   localparam logic [7:0] VFR_OV_ACTION_RESET = 8'hBF;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int VFR_CLK_PERIOD_NS = 10;
   localparam int VFR_RETRY_RISE_TIMES = 7;
   localparam int VFR_RISE_TIME_US = 1;
   localparam int VFR_RISE_TIME_CYCLES = (VFR_RISE_TIME_US * 1000 + VFR_CLK_PERIOD_NS - 1) / VFR_CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      VFR_ST_RUN = 2'h0,
      VFR_ST_OFF = 2'h1,
      VFR_ST_WAIT = 2'h3,
      VFR_ST_START = 2'h2
   } vfr_state_t;
endpackage

// ---- vfr_retry_ctl.sv ----
`timescale 1ns/1ps
// One fault channel: decides ignore or shutdown and runs the restart policy.
module vfr_retry_ctl #(
   parameter int RISE_CYCLES = 100
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Configuration and events
   input wire logic [7:0] action_in,
   input wire logic fault_in,
   input wire logic fault_clear_in,
   input wire logic abort_in,
   input wire logic start_done_in,
   // Outputs
   output logic shutdown_out,
   output logic restart_out
);
   import vfr_pkg::*;
   if (RISE_CYCLES < 1) begin : g_bad_rise
      $error("vfr_retry_ctl: RISE_CYCLES must be at least one");
   end
   localparam int WAIT_CYCLES = VFR_RETRY_RISE_TIMES * RISE_CYCLES;
   vfr_state_t state_reg;
   logic [31:0] wait_cnt_reg;
   wire ignore_w = ~action_in[VFR_IGNORE_SELECT_BIT];
   wire retry_w = action_in[VFR_RETRY_MODE_MSB];

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= VFR_ST_RUN;
         wait_cnt_reg <= 32'h0;
         shutdown_out <= 1'b0;
         restart_out <= 1'b0;
      end else begin
         restart_out <= 1'b0;
         case (state_reg)
            VFR_ST_RUN: begin
               // Ignore mode keeps regulating; flags are raised elsewhere.
               if (fault_in && !ignore_w) begin
                  shutdown_out <= 1'b1;
                  wait_cnt_reg <= 32'h0;
                  state_reg <= retry_w ? VFR_ST_WAIT : VFR_ST_OFF;
               end
            end
            VFR_ST_OFF: begin
               // Latched off with no delay until the fault is cleared.
               if (fault_clear_in) begin
                  shutdown_out <= 1'b0;
                  state_reg <= VFR_ST_RUN;
               end
            end
            VFR_ST_WAIT: begin
               if (abort_in) begin
                  state_reg <= VFR_ST_OFF;
               end else if (wait_cnt_reg == 32'(WAIT_CYCLES - 1)) begin
                  // Seven rise times elapsed, start a fresh soft-start.
                  restart_out <= 1'b1;
                  shutdown_out <= 1'b0;
                  state_reg <= VFR_ST_START;
               end else begin
                  wait_cnt_reg <= wait_cnt_reg + 32'h1;
               end
            end
            VFR_ST_START: begin
               // Retries are unlimited; a fresh fault goes round again.
               if (abort_in) begin
                  shutdown_out <= 1'b1;
                  state_reg <= VFR_ST_OFF;
               end else if (fault_in && !ignore_w) begin
                  shutdown_out <= 1'b1;
                  wait_cnt_reg <= 32'h0;
                  state_reg <= retry_w ? VFR_ST_WAIT : VFR_ST_OFF;
               end else if (start_done_in) begin
                  state_reg <= VFR_ST_RUN;
               end
            end
            default: state_reg <= VFR_ST_RUN;
         endcase
      end
   end
endmodule

// ---- vfr_fault_action.sv ----
`timescale 1ns/1ps
module vfr_fault_action #(
   parameter int RISE_CYCLES = vfr_pkg::VFR_RISE_TIME_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Command port from the PMBus engine
   input wire logic cmd_valid_in,
   input wire logic cmd_write_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [7:0] cmd_wdata_in,
   input wire logic store_all_in,
   input wire logic restore_all_in,
   input wire logic loop_slave_in,
   // Nonvolatile store
   input wire logic nv_ov_bit7_in,
   input wire logic nv_ov_bit5_in,
   input wire logic nv_uv_bit7_in,
   input wire logic nv_uv_bit5_in,
   // Fault events and power state
   input wire logic ov_fault_in,
   input wire logic uv_fault_in,
   input wire logic fault_clear_in,
   input wire logic commanded_off_in,
   input wire logic bias_lost_in,
   input wire logic other_shutdown_in,
   input wire logic start_done_in,
   input wire logic status_clear_in,
   input wire logic alert_mask_in,
   // Command answer
   output logic [7:0] cmd_rdata_out,
   output logic cmd_nack_out,
   output logic cmd_ack_out,
   // Nonvolatile write
   output logic nv_write_out,
   output logic [1:0] nv_ov_bits_out,
   output logic [1:0] nv_uv_bits_out,
   // Status flags
   output logic comm_fault_out,
   output logic invalid_data_out,
   output logic invalid_command_fault_out,
   output logic ov_status_out,
   output logic other_fault_out,
   output logic output_voltage_flag_out,
   output logic ov_vout_flag_out,
   output logic undervoltage_flag_out,
   output logic smbalert_n_out,
   // Power stage control
   output logic output_enable_out,
   output logic soft_start_out
);
   import vfr_pkg::*;

   // ****************************************************************
   // Register storage
   // ****************************************************************
   // Only bits 7 and 5 are held: the mode field is three copies of bit 5
   // and the delay field mirrors it, so no illegal state can be stored.
   logic ov_ignore_reg, ov_retry_reg, uv_ignore_reg, uv_retry_reg;
   logic [7:0] ov_byte, uv_byte;
   logic [2:0] wmode;
   logic mode_ok, hit_ov, hit_uv, uv_blocked;

   function automatic logic [7:0] vfr_pack(input logic ign, input logic rty);
      vfr_pack = {ign, 1'b0, {3{rty}}, {3{rty}}};
   endfunction

   assign ov_byte = vfr_pack(ov_ignore_reg, ov_retry_reg);
   assign uv_byte = vfr_pack(uv_ignore_reg, uv_retry_reg);
   assign wmode = cmd_wdata_in[VFR_RETRY_MODE_MSB:VFR_RETRY_MODE_LSB];
   assign mode_ok = (wmode == VFR_RETRY_NONE) || (wmode == VFR_RETRY_ALWAYS);
   assign hit_ov = cmd_valid_in && (cmd_code_in == VFR_CMD_OV_ACTION);
   assign hit_uv = cmd_valid_in && (cmd_code_in == VFR_CMD_UV_ACTION);
   assign uv_blocked = hit_uv && loop_slave_in;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ov_ignore_reg <= VFR_OV_ACTION_RESET[VFR_IGNORE_SELECT_BIT];
         ov_retry_reg <= VFR_OV_ACTION_RESET[VFR_RETRY_MODE_MSB];
         uv_ignore_reg <= VFR_UV_ACTION_RESET[VFR_IGNORE_SELECT_BIT];
         uv_retry_reg <= VFR_UV_ACTION_RESET[VFR_RETRY_MODE_MSB];
      end else if (restore_all_in) begin
         // Field rebuilt from the single stored bit.
         ov_ignore_reg <= nv_ov_bit7_in;
         ov_retry_reg <= nv_ov_bit5_in;
         uv_ignore_reg <= nv_uv_bit7_in;
         uv_retry_reg <= nv_uv_bit5_in;
      end else if (cmd_write_in && mode_ok) begin
         // A refused value leaves both bits untouched.
         if (hit_ov) begin
            ov_ignore_reg <= cmd_wdata_in[VFR_IGNORE_SELECT_BIT];
            ov_retry_reg <= cmd_wdata_in[VFR_RETRY_MODE_MSB];
         end
         if (hit_uv && !loop_slave_in) begin
            uv_ignore_reg <= cmd_wdata_in[VFR_IGNORE_SELECT_BIT];
            uv_retry_reg <= cmd_wdata_in[VFR_RETRY_MODE_MSB];
         end
      end
   end

   // ****************************************************************
   // Command answer and nonvolatile store
   // ****************************************************************
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cmd_rdata_out <= 8'h00;
         cmd_nack_out <= 1'b0;
         cmd_ack_out <= 1'b0;
      end else begin
         cmd_nack_out <= uv_blocked;
         cmd_ack_out <= (hit_ov || hit_uv) && !uv_blocked;
         if (hit_ov && !cmd_write_in) begin
            cmd_rdata_out <= ov_byte;
         end else if (hit_uv && !cmd_write_in && !loop_slave_in) begin
            cmd_rdata_out <= uv_byte;
         end else begin
            cmd_rdata_out <= 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         nv_write_out <= 1'b0;
         nv_ov_bits_out <= 2'h0;
         nv_uv_bits_out <= 2'h0;
      end else begin
         nv_write_out <= store_all_in;
         if (store_all_in) begin
            nv_ov_bits_out <= {ov_ignore_reg, ov_retry_reg};
            nv_uv_bits_out <= {uv_ignore_reg, uv_retry_reg};
         end
      end
   end

   // ****************************************************************
   // Status flags and alert
   // ****************************************************************
   // Flags are sticky; an event in the clearing cycle wins over the clear.
   logic bad_write, ivc_evt, any_evt;
   assign bad_write = cmd_write_in && (hit_ov || (hit_uv && !loop_slave_in)) && !mode_ok;
   assign ivc_evt = uv_blocked;
   assign any_evt = bad_write || ivc_evt || ov_fault_in || uv_fault_in;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         comm_fault_out <= 1'b0;
         invalid_data_out <= 1'b0;
         invalid_command_fault_out <= 1'b0;
         ov_status_out <= 1'b0;
         other_fault_out <= 1'b0;
         output_voltage_flag_out <= 1'b0;
         ov_vout_flag_out <= 1'b0;
         undervoltage_flag_out <= 1'b0;
      end else begin
         comm_fault_out <= (bad_write || ivc_evt) || (comm_fault_out && !status_clear_in);
         invalid_data_out <= bad_write || (invalid_data_out && !status_clear_in);
         invalid_command_fault_out <= ivc_evt || (invalid_command_fault_out && !status_clear_in);
         ov_status_out <= ov_fault_in || (ov_status_out && !status_clear_in);
         ov_vout_flag_out <= ov_fault_in || (ov_vout_flag_out && !status_clear_in);
         other_fault_out <= uv_fault_in || (other_fault_out && !status_clear_in);
         undervoltage_flag_out <= uv_fault_in || (undervoltage_flag_out && !status_clear_in);
         output_voltage_flag_out <= ov_fault_in || uv_fault_in ||
            (output_voltage_flag_out && !status_clear_in);
      end
   end

   // Alert is held until status is cleared; the mask only gates the pin.
   logic alert_pend_reg;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         alert_pend_reg <= 1'b0;
         smbalert_n_out <= 1'b1;
      end else begin
         alert_pend_reg <= any_evt || (alert_pend_reg && !status_clear_in);
         smbalert_n_out <= !((any_evt || (alert_pend_reg && !status_clear_in)) && !alert_mask_in);
      end
   end

   // ****************************************************************
   // Fault response channels
   // ****************************************************************
   logic abort_w, ov_shut, uv_shut, ov_rst, uv_rst;
   assign abort_w = commanded_off_in || bias_lost_in || other_shutdown_in;

   vfr_retry_ctl #(.RISE_CYCLES(RISE_CYCLES)) u_ov_ctl (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .action_in(ov_byte),
      .fault_in(ov_fault_in),
      .fault_clear_in(fault_clear_in),
      .abort_in(abort_w),
      .start_done_in(start_done_in),
      .shutdown_out(ov_shut),
      .restart_out(ov_rst)
   );

   vfr_retry_ctl #(.RISE_CYCLES(RISE_CYCLES)) u_uv_ctl (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .action_in(uv_byte),
      .fault_in(uv_fault_in),
      .fault_clear_in(fault_clear_in),
      .abort_in(abort_w),
      .start_done_in(start_done_in),
      .shutdown_out(uv_shut),
      .restart_out(uv_rst)
   );

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         output_enable_out <= 1'b0;
         soft_start_out <= 1'b0;
      end else begin
         output_enable_out <= !(ov_shut || uv_shut) && !commanded_off_in;
         soft_start_out <= ov_rst || uv_rst;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_bad_write_flags;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      bad_write |=> invalid_data_out && comm_fault_out;
   endproperty
   a_bad_write_flags: assert property (p_bad_write_flags) else $error("rejected write lacks flags");

   property p_bad_write_keeps;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (bad_write && hit_ov && !restore_all_in) |=> $stable(ov_byte);
   endproperty
   a_bad_write_keeps: assert property (p_bad_write_keeps) else $error("rejected write changed register");

   property p_delay_mirror;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      uv_byte[2:0] == {3{uv_byte[5]}} && !uv_byte[6] && ov_byte[2:0] == {3{ov_byte[5]}};
   endproperty
   a_delay_mirror: assert property (p_delay_mirror) else $error("delay bits do not mirror bit 5");

   property p_uv_flags;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      uv_fault_in |=> other_fault_out && undervoltage_flag_out && output_voltage_flag_out;
   endproperty
   a_uv_flags: assert property (p_uv_flags) else $error("undervoltage flags missing");

   property p_ov_flags;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (ov_fault_in && !alert_mask_in) |=> ov_status_out && ov_vout_flag_out && !smbalert_n_out;
   endproperty
   a_ov_flags: assert property (p_ov_flags) else $error("overvoltage flags or alert missing");

   property p_slave_nack;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      uv_blocked |=> cmd_nack_out && invalid_command_fault_out && !cmd_ack_out;
   endproperty
   a_slave_nack: assert property (p_slave_nack) else $error("loop slave access not refused");

   property p_slave_write_ignored;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (uv_blocked && cmd_write_in && !restore_all_in) |=> $stable(uv_byte);
   endproperty
   a_slave_write_ignored: assert property (p_slave_write_ignored) else $error("loop slave write took effect");

   property p_store;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      store_all_in |=> nv_write_out && nv_uv_bits_out == {$past(uv_byte[7]), $past(uv_byte[5])};
   endproperty
   a_store: assert property (p_store) else $error("store did not copy register");

   property p_ignore_runs;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (uv_fault_in && !uv_byte[7] && !ov_shut && !uv_shut && !commanded_off_in) |=> output_enable_out;
   endproperty
   a_ignore_runs: assert property (p_ignore_runs) else $error("ignore mode stopped the output");

   property p_shutdown;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (uv_fault_in && uv_byte[7]) |=> ##1 !output_enable_out;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("shutdown mode kept output on");

   // Watched on the channel itself, so a restart of the other channel cannot mask or fake it.
   property p_latch_off;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (ov_fault_in && ov_byte[7] && !ov_byte[5] && !ov_shut) |=> !ov_rst [*8];
   endproperty
   a_latch_off: assert property (p_latch_off) else $error("latched mode restarted");

   property p_abort_stops;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      abort_w |=> ##1 !soft_start_out;
   endproperty
   a_abort_stops: assert property (p_abort_stops) else $error("restart despite stop request");

   property p_alert_mask;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      alert_mask_in |=> smbalert_n_out;
   endproperty
   a_alert_mask: assert property (p_alert_mask) else $error("masked alert reached the pin");

   property p_uv_bad_keeps;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (bad_write && hit_uv && !restore_all_in) |=> $stable(uv_byte);
   endproperty
   a_uv_bad_keeps: assert property (p_uv_bad_keeps) else $error("rejected write changed register");

   property p_good_write;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (cmd_write_in && hit_ov && mode_ok && !restore_all_in) |=>
         ov_byte[7] == $past(cmd_wdata_in[7]) && ov_byte[5] == $past(cmd_wdata_in[5]);
   endproperty
   a_good_write: assert property (p_good_write) else $error("accepted write not stored");

   property p_slave_read_zero;
      @(posedge ref_clk_in) disable iff (!reset_n_in)
      (uv_blocked && !cmd_write_in) |=> cmd_rdata_out == 8'h00;
   endproperty
   a_slave_read_zero: assert property (p_slave_read_zero) else $error("refused read returned data");

   c_uv_fault: cover property (@(posedge ref_clk_in) uv_fault_in && uv_byte[7]);
   c_restart: cover property (@(posedge ref_clk_in) soft_start_out);
   c_reject: cover property (@(posedge ref_clk_in) bad_write);
   c_slave: cover property (@(posedge ref_clk_in) uv_blocked);
endmodule

// ---- vfr_host_model.sv ----
`timescale 1ns/1ps
// Behavioural PMBus host that issues one single-byte command at a time.
module vfr_host_model (
   // Clock
   input wire logic ref_clk_in,
   // Command answer
   input wire logic [7:0] cmd_rdata_in,
   input wire logic cmd_ack_in,
   input wire logic cmd_nack_in,
   // Command request
   output logic cmd_valid_out,
   output logic cmd_write_out,
   output logic [7:0] cmd_code_out,
   output logic [7:0] cmd_wdata_out
);
   initial begin
      cmd_valid_out = 1'b0;
      cmd_write_out = 1'b0;
      cmd_code_out = 8'h00;
      cmd_wdata_out = 8'h00;
   end
   // The byte goes out as given: only a test that wants a refusal sends a mixed mode field.
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] wdata, input int gap,
                       output logic [7:0] rdata, output logic ack, output logic nack);
      repeat (gap) @(posedge ref_clk_in);
      @(posedge ref_clk_in);
      #1;
      cmd_valid_out = 1'b1;
      cmd_write_out = wr;
      cmd_code_out = code;
      cmd_wdata_out = wdata;
      @(posedge ref_clk_in);
      #1;
      rdata = cmd_rdata_in;
      ack = cmd_ack_in;
      nack = cmd_nack_in;
      cmd_valid_out = 1'b0;
      // Released lines toggle so that a stale byte can never pass for a fresh one.
      cmd_write_out = ~cmd_write_out;
      cmd_code_out = ~cmd_code_out;
      cmd_wdata_out = ~cmd_wdata_out;
   endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import vfr_pkg::*;
   localparam int RC = 2;
   logic ref_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic cmd_valid, cmd_write, cmd_nack, cmd_ack, nv_write, ak, nk;
   logic [7:0] cmd_code, cmd_wdata, cmd_rdata, rd;
   logic store_all, restore_all, loop_slave, nv_ov7, nv_ov5, nv_uv7, nv_uv5;
   logic ov_fault, uv_fault, fault_clear, cmd_off, bias_lost, other_sd, start_done, status_clear, alert_mask;
   logic [1:0] nv_ov_bits, nv_uv_bits;
   logic comm_fault, inv_data, invalid_command_fault, ov_status, other_fault, vout_flag, ov_vout, uv_flag, alert_n, oe, soft_start;
   int fail_count = 0;
   int check_count = 0;
   int ss_count = 0;
   int n;
   int base;
   logic [7:0] wtab [4] = '{8'h38, 8'h47, 8'hF8, 8'h80};
   logic [7:0] etab [4] = '{8'h3F, 8'h00, 8'hBF, 8'h80};

   always #5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      if (soft_start === 1'b1) begin
         ss_count++;
      end
   end

   vfr_host_model u_host (.ref_clk_in(ref_clk_in), .cmd_rdata_in(cmd_rdata), .cmd_ack_in(cmd_ack),
      .cmd_nack_in(cmd_nack), .cmd_valid_out(cmd_valid), .cmd_write_out(cmd_write), .cmd_code_out(cmd_code),
      .cmd_wdata_out(cmd_wdata));

   vfr_fault_action #(.RISE_CYCLES(RC)) dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
      .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_code_in(cmd_code), .cmd_wdata_in(cmd_wdata),
      .store_all_in(store_all), .restore_all_in(restore_all), .loop_slave_in(loop_slave),
      .nv_ov_bit7_in(nv_ov7), .nv_ov_bit5_in(nv_ov5), .nv_uv_bit7_in(nv_uv7), .nv_uv_bit5_in(nv_uv5),
      .ov_fault_in(ov_fault), .uv_fault_in(uv_fault), .fault_clear_in(fault_clear),
      .commanded_off_in(cmd_off), .bias_lost_in(bias_lost), .other_shutdown_in(other_sd),
      .start_done_in(start_done), .status_clear_in(status_clear), .alert_mask_in(alert_mask),
      .cmd_rdata_out(cmd_rdata), .cmd_nack_out(cmd_nack), .cmd_ack_out(cmd_ack), .nv_write_out(nv_write),
      .nv_ov_bits_out(nv_ov_bits), .nv_uv_bits_out(nv_uv_bits), .comm_fault_out(comm_fault),
      .invalid_data_out(inv_data), .invalid_command_fault_out(invalid_command_fault), .ov_status_out(ov_status),
      .other_fault_out(other_fault), .output_voltage_flag_out(vout_flag), .ov_vout_flag_out(ov_vout),
      .undervoltage_flag_out(uv_flag), .smbalert_n_out(alert_n), .output_enable_out(oe),
      .soft_start_out(soft_start));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic tick(input int cnt);
      repeat (cnt) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic wrreg(input logic [7:0] code, input logic [7:0] data);
      u_host.xfer(1'b1, code, data, 0, rd, ak, nk);
      chk("write_answer", 8'h02, {6'h00, ak, nk});
   endtask
   task automatic rdreg(input logic [7:0] code, input logic [7:0] exp);
      u_host.xfer(1'b0, code, 8'h00, 1, rd, ak, nk);
      chk("read_answer", 8'h02, {6'h00, ak, nk});
      chk("read_data", exp, rd);
   endtask
   task automatic clr();
      status_clear = 1'b1;
      tick(1);
      status_clear = 1'b0;
      tick(1);
      chk("alert_idle", 8'h01, {7'h00, alert_n});
   endtask
   task automatic fault(input logic uv);
      uv_fault = uv;
      ov_fault = ~uv;
      tick(1);
      uv_fault = 1'b0;
      ov_fault = 1'b0;
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {store_all, restore_all, loop_slave, nv_ov7, nv_ov5, nv_uv7, nv_uv5} = 7'h00;
      {ov_fault, uv_fault, fault_clear, cmd_off, bias_lost, other_sd, start_done, status_clear} = 8'h00;
      alert_mask = 1'b0;
      tick(2);
      chk("alert_in_reset", 8'h01, {7'h00, alert_n});
      reset_n_in = 1'b1;
      tick(1);
      chk("enable_after_reset", 8'h01, {7'h00, oe});
      rdreg(VFR_CMD_UV_ACTION, 8'hBF);
      rdreg(VFR_CMD_OV_ACTION, 8'hBF);
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < 4; i++) begin
            wrreg(c[0] ? VFR_CMD_OV_ACTION : VFR_CMD_UV_ACTION, wtab[i]);
            rdreg(c[0] ? VFR_CMD_OV_ACTION : VFR_CMD_UV_ACTION, etab[i]);
         end
      end
      chk("no_comm_fault", 8'h00, {7'h00, comm_fault});
      for (int m = 1; m < 7; m++) begin
         wrreg(m[0] ? VFR_CMD_OV_ACTION : VFR_CMD_UV_ACTION, {2'b00, m[2:0], 3'b000});
         tick(1);
         chk("refused_flags", 8'h06, {5'h00, inv_data, comm_fault, alert_n});
         rdreg(m[0] ? VFR_CMD_OV_ACTION : VFR_CMD_UV_ACTION, 8'h80);
         clr();
      end
      loop_slave = 1'b1;
      u_host.xfer(1'b0, VFR_CMD_UV_ACTION, 8'h00, 1, rd, ak, nk);
      chk("slave_read_answer", 8'h01, {6'h00, ak, nk});
      tick(1);
      chk("slave_flags", 8'h06, {5'h00, invalid_command_fault, comm_fault, alert_n});
      u_host.xfer(1'b1, VFR_CMD_UV_ACTION, 8'hB8, 0, rd, ak, nk);
      chk("slave_write_answer", 8'h01, {6'h00, ak, nk});
      loop_slave = 1'b0;
      clr();
      rdreg(VFR_CMD_UV_ACTION, 8'h80);
      wrreg(VFR_CMD_UV_ACTION, 8'h38);
      store_all = 1'b1;
      tick(1);
      store_all = 1'b0;
      chk("store_pulse", 8'h01, {7'h00, nv_write});
      chk("stored_bits", 8'h09, {4'h0, nv_ov_bits, nv_uv_bits});
      {nv_ov7, nv_ov5, nv_uv7, nv_uv5} = 4'b0111;
      restore_all = 1'b1;
      tick(1);
      restore_all = 1'b0;
      rdreg(VFR_CMD_UV_ACTION, 8'hBF);
      rdreg(VFR_CMD_OV_ACTION, 8'h3F);
      // Two faults in a row: the restart must repeat without an attempt limit.
      for (int r = 0; r < 2; r++) begin
         fault(1'b1);
         chk("uv_flags", 8'h0E, {4'h0, other_fault, vout_flag, uv_flag, alert_n});
         tick(2);
         chk("shut_down", 8'h00, {7'h00, oe});
         n = 3;
         while (soft_start !== 1'b1 && n < 100) begin
            tick(1);
            n++;
         end
         chk("retry_delay", 8'h01, {7'h00, (n >= 7 * RC - 1 && n <= 7 * RC + 3)});
         start_done = 1'b1;
         tick(1);
         start_done = 1'b0;
         tick(1);
         chk("restarted", 8'h01, {7'h00, oe});
         clr();
      end
      wrreg(VFR_CMD_OV_ACTION, 8'h80);
      base = ss_count;
      fault(1'b0);
      chk("ov_flags", 8'h0E, {4'h0, ov_status, ov_vout, vout_flag, alert_n});
      tick(7 * RC + 6);
      chk("latched_off", 8'h00, {6'h00, oe, ss_count != base});
      fault_clear = 1'b1;
      tick(1);
      fault_clear = 1'b0;
      tick(3);
      chk("cleared_on", 8'h01, {7'h00, oe});
      clr();
      wrreg(VFR_CMD_UV_ACTION, 8'h38);
      for (int a = 0; a < 2; a++) begin
         alert_mask = a[0];
         fault(1'b1);
         tick(3);
         chk("ignore_mode", {5'h00, 2'b11, a[0]}, {5'h00, oe, uv_flag, alert_n});
         alert_mask = 1'b0;
         clr();
      end
      wrreg(VFR_CMD_UV_ACTION, 8'hBF);
      for (int k = 0; k < 3; k++) begin
         base = ss_count;
         fault(1'b1);
         tick(2);
         {cmd_off, bias_lost, other_sd} = 3'b100 >> k;
         tick(7 * RC + 6);
         chk("stop_retry", 8'h00, {6'h00, oe, ss_count != base});
         {cmd_off, bias_lost, other_sd} = 3'b000;
         fault_clear = 1'b1;
         tick(1);
         fault_clear = 1'b0;
         tick(3);
         chk("resume", 8'h01, {7'h00, oe});
         clr();
      end
      tally_and_finish();
   end

   // A hang in any wait above ends the run here instead.
   initial begin
      repeat (4000) @(posedge ref_clk_in);
      fail_count++;
      tally_and_finish();
   end
endmodule
